/* design/cse_defines.svh */
/*
 * constants for the context switch and exception entry block:
 * save area geometry, word slots, trap classes and id numbers.
 * assumes inclusion by bare name from the package and the design.
 */
`ifndef CSE_DEFINES_SVH
`define CSE_DEFINES_SVH

// save area geometry
`define CSE_AREA_WORDS      5'h10
`define CSE_AREA_SHIFT      4
`define CSE_LINK_END        16'h0000
// word slots inside an upper save area
`define CSE_UP_LINK         4'h0
`define CSE_UP_PSW          4'h1
`define CSE_UP_A10          4'h2
`define CSE_UP_D8           4'h8
// word slots inside a lower save area
`define CSE_LO_LINK         4'h0
`define CSE_LO_PC           4'h1
`define CSE_LO_A2           4'h2
`define CSE_LO_D0           4'h8
// trap classes
`define CSE_NUM_CLASSES     8
`define CSE_CLS_CTX         3'h3
`define CSE_CLS_NMI         3'h7
// id number for free list exhausted
`define CSE_TIN_FREE_EMPTY  8'h04
// idle priority
`define CSE_PRIO_NONE       8'h00

`endif

/* design/cse_pkg.sv */
/*
 * types for the context switch and exception entry block.
 * assumes cse_defines.svh is on the include path.
 */
`include "cse_defines.svh"

package cse_pkg;
    typedef logic [31:0] cse_word_t;
    typedef logic [15:0] cse_ptr_t;

    // requests from the pipeline
    typedef enum logic [2:0] {
        CSE_OP_NONE      = 3'h0,
        CSE_OP_CALL      = 3'h1,
        CSE_OP_RET       = 3'h2,
        CSE_OP_SAVE_LO   = 3'h3,
        CSE_OP_RESTORE_LO= 3'h4
    } cse_op_e;

    typedef enum logic [6:0] {
        CSE_ST_IDLE  = 7'h01,
        CSE_ST_SAVE  = 7'h02,
        CSE_ST_LOAD  = 7'h04,
        CSE_ST_SAVEL = 7'h08,
        CSE_ST_LOADL = 7'h10,
        CSE_ST_FREE  = 7'h20,
        CSE_ST_DONE  = 7'h40
    } cse_state_e;
endpackage

/* design/cse_context_unit.sv */
/*
 * context switch and exception entry: saves and reloads task contexts
 * in 16-word save areas chained through a link word, keeps the free
 * list, and picks interrupt or trap entry.
 * assumes the pipeline holds a request steady until done pulses, and
 * that the save memory answers reads in the same cycle (mem_rdata).
 */
`timescale 1ns/1ns
`default_nettype none
`include "cse_defines.svh"

module cse_context_unit #(
    parameter int NUM_SRC   = 8,
    parameter int PRIO_W    = 8,
    parameter int TIN_W     = 8
) (
    input  wire logic                      clk,           // core clock
    input  wire logic                      rst_n,         // async reset
    input  wire cse_pkg::cse_op_e          op,            // pipeline request
    input  wire cse_pkg::cse_word_t        ret_pc,        // pc to save
    input  wire cse_pkg::cse_ptr_t         free_head_in,  // initial free list
    input  wire logic                      free_load,     // load free head
    input  wire logic [NUM_SRC-1:0]        irq_req,       // interrupt lines
    input  wire logic [NUM_SRC*PRIO_W-1:0] irq_prio,      // programmed prios
    input  wire logic [`CSE_NUM_CLASSES-1:0] trap_req,    // trap per class
    input  wire logic [`CSE_NUM_CLASSES*TIN_W-1:0] trap_tin, // id per class
    input  wire cse_pkg::cse_word_t        gpr_rdata [32],// register file
    input  wire cse_pkg::cse_word_t        psw_in,        // status word
    input  wire cse_pkg::cse_word_t        mem_rdata [16],// area burst read
    output cse_pkg::cse_ptr_t              mem_addr,      // area word addr
    output logic                           mem_we,        // burst write
    output logic                           mem_re,        // burst read
    output cse_pkg::cse_word_t             mem_wdata [16],// burst data
    output logic                           gpr_we,        // reload strobe
    output logic [31:0]                    gpr_wmask,     // regs reloaded
    output cse_pkg::cse_word_t             gpr_wdata [32],// reload data
    output cse_pkg::cse_word_t             psw_out,       // restored psw
    output cse_pkg::cse_word_t             pc_out,        // restored pc
    output cse_pkg::cse_word_t             previous_context_info_out,      // prev ctx info
    output logic                           entry_valid,   // branch pulse
    output logic                           entry_is_trap, // trap vs irq
    output logic [TIN_W-1:0]               entry_vector,  // block index
    output logic [PRIO_W-1:0]              cur_prio,      // running prio
    output logic                           done           // op complete
);
    import cse_pkg::*;

    typedef struct packed {
        cse_state_e          state;
        cse_ptr_t            free_head;
        cse_word_t           previous_context_info;
        cse_ptr_t            addr;
        logic                we;
        logic                re;
        logic [16*32-1:0]    wbuf;
        logic                gwe;
        logic [31:0]         gmask;
        logic [32*32-1:0]    gbuf;
        cse_word_t           program_status_word;
        cse_word_t           pc;
        logic                ev;
        logic                etrap;
        logic [TIN_W-1:0]    evec;
        logic [PRIO_W-1:0]   prio;
        logic                is_irq;
        logic                done;
    } cse_st_s;

    cse_st_s s_reg;
    cse_st_s s_next;

    // link pointer field of previous context info
    function automatic cse_ptr_t link_of(input cse_word_t w);
        return w[15:0];
    endfunction

    // word address of an area from its link pointer
    function automatic cse_ptr_t area_addr(input cse_ptr_t p);
        return cse_ptr_t'({p[15-`CSE_AREA_SHIFT:0], {`CSE_AREA_SHIFT{1'b0}}});
    endfunction

    ////////////////////////////////////////////////////////////////////
    // arbitration: highest pending interrupt, lowest trap id
    logic [PRIO_W-1:0] best_prio;
    logic              trap_any;
    logic [TIN_W-1:0]  best_tin;
    always_comb begin
        best_prio = PRIO_W'(`CSE_PRIO_NONE);
        trap_any  = 1'b0;
        best_tin  = '1;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (irq_req[i] && irq_prio[i*PRIO_W +: PRIO_W] > best_prio) begin
                best_prio = irq_prio[i*PRIO_W +: PRIO_W];
            end
        end
        for (int c = 0; c < `CSE_NUM_CLASSES; c++) begin
            if (trap_req[c] && (!trap_any || trap_tin[c*TIN_W +: TIN_W] < best_tin)) begin
                trap_any = 1'b1;
                best_tin = trap_tin[c*TIN_W +: TIN_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state; one request or entry handled at a time
    always_comb begin
        s_next      = s_reg;
        s_next.we   = 1'b0;
        s_next.re   = 1'b0;
        s_next.gwe  = 1'b0;
        s_next.ev   = 1'b0;
        s_next.done = 1'b0;
        if (free_load) begin
            s_next.free_head = free_head_in;
        end
        case (s_reg.state)
            CSE_ST_IDLE: begin
                // traps beat interrupts; calls wait for idle
                // strictly higher only
                if (trap_any || best_prio > s_reg.prio || op == CSE_OP_CALL) begin
                    s_next.etrap  = trap_any;
                    s_next.is_irq = !trap_any && best_prio > s_reg.prio;
                    s_next.evec   = trap_any ? best_tin : TIN_W'(best_prio);
                    s_next.state  = CSE_ST_SAVE;
                end else if (op == CSE_OP_RET) begin
                    s_next.state = CSE_ST_LOAD;
                end else if (op == CSE_OP_SAVE_LO) begin
                    s_next.state = CSE_ST_SAVEL;
                end else if (op == CSE_OP_RESTORE_LO) begin
                    s_next.state = CSE_ST_LOADL;
                end
            end
            CSE_ST_SAVE, CSE_ST_SAVEL: begin
                if (s_reg.free_head == `CSE_LINK_END) begin
                    s_next.etrap  = 1'b1;
                    s_next.is_irq = 1'b0;
                    s_next.evec   = TIN_W'(`CSE_TIN_FREE_EMPTY);
                    s_next.ev     = 1'b1;
                    s_next.state  = CSE_ST_DONE;
                end else begin
                    s_next.addr  = area_addr(s_reg.free_head);
                    s_next.re    = 1'b1;
                    s_next.state = CSE_ST_FREE;
                end
            end
            CSE_ST_FREE: begin
                // head area link read this cycle gives new free head
                // one sixteen-word burst
                s_next.free_head = link_of(mem_rdata[0]);
                s_next.we        = 1'b1;
                for (int k = 0; k < 16; k++) begin
                    s_next.wbuf[k*32 +: 32] = '0;
                end
                s_next.wbuf[`CSE_UP_LINK*32 +: 32] = s_reg.previous_context_info;
                if (s_reg.gmask[0]) begin
                    // lower save
                    s_next.wbuf[`CSE_LO_PC*32 +: 32] = ret_pc;
                    for (int k = 0; k < 6; k++) begin
                        s_next.wbuf[(`CSE_LO_A2+k)*32 +: 32] = gpr_rdata[18+k];
                    end
                    for (int k = 0; k < 8; k++) begin
                        s_next.wbuf[(`CSE_LO_D0+k)*32 +: 32] = gpr_rdata[k];
                    end
                end else begin
                    // upper set; A0 A1 A8 A9 skipped
                    s_next.wbuf[`CSE_UP_PSW*32 +: 32] = psw_in;
                    for (int k = 0; k < 6; k++) begin
                        s_next.wbuf[(`CSE_UP_A10+k)*32 +: 32] = gpr_rdata[26+k];
                    end
                    for (int k = 0; k < 8; k++) begin
                        s_next.wbuf[(`CSE_UP_D8+k)*32 +: 32] = gpr_rdata[8+k];
                    end
                end
                s_next.previous_context_info  = {16'h0000, s_reg.free_head};
                // only an interrupt or trap branches; calls and lower saves
                // go on in line, and stale kind flags must not fire an entry
                s_next.ev    = !s_reg.gmask[0]
                               && (s_reg.etrap || s_reg.is_irq);
                if (s_reg.is_irq && !s_reg.gmask[0]) begin
                    s_next.prio = PRIO_W'(s_reg.evec);
                end
                if (s_reg.etrap && !s_reg.gmask[0]) begin
                    s_next.gwe         = 1'b1;
                    s_next.gmask       = 32'h0000_8000;
                    s_next.gbuf[15*32 +: 32] = 32'(s_reg.evec);
                end
                s_next.state = CSE_ST_DONE;
            end
            CSE_ST_LOAD, CSE_ST_LOADL: begin
                s_next.addr  = area_addr(link_of(s_reg.previous_context_info));
                s_next.re    = 1'b1;
                s_next.state = CSE_ST_DONE;
                s_next.gmask = (s_reg.state == CSE_ST_LOADL) ? 32'hffff_ffff : '0;
            end
            CSE_ST_DONE: begin
                if (s_reg.re) begin
                    s_next.gwe = 1'b1;
                    s_next.gbuf = '0;
                    if (s_reg.gmask[0]) begin
                        s_next.gmask = 32'h00fc_00ff;
                        s_next.pc    = mem_rdata[`CSE_LO_PC];
                        for (int k = 0; k < 6; k++) begin
                            s_next.gbuf[(18+k)*32 +: 32] = mem_rdata[`CSE_LO_A2+k];
                        end
                        for (int k = 0; k < 8; k++) begin
                            s_next.gbuf[k*32 +: 32] = mem_rdata[`CSE_LO_D0+k];
                        end
                    end else begin
                        s_next.gmask = 32'hfc00_ff00;
                        s_next.program_status_word   = mem_rdata[`CSE_UP_PSW];
                        s_next.prio  = PRIO_W'(`CSE_PRIO_NONE);
                        for (int k = 0; k < 6; k++) begin
                            s_next.gbuf[(26+k)*32 +: 32] = mem_rdata[`CSE_UP_A10+k];
                        end
                        for (int k = 0; k < 8; k++) begin
                            s_next.gbuf[(8+k)*32 +: 32] = mem_rdata[`CSE_UP_D8+k];
                        end
                    end
                    s_next.previous_context_info = mem_rdata[`CSE_UP_LINK];
                    s_next.we   = 1'b1;
                    s_next.wbuf = '0;
                    s_next.wbuf[31:0] = {16'h0000, s_reg.free_head};
                    s_next.free_head  = link_of(s_reg.previous_context_info);
                end
                s_next.done  = 1'b1;
                s_next.state = CSE_ST_IDLE;
            end
            default: begin
                s_next.state = CSE_ST_IDLE;
            end
        endcase
        // lower requests flag their kind in mask bit 0 until used
        if (s_reg.state == CSE_ST_IDLE) begin
            s_next.gmask = {31'h0, op == CSE_OP_SAVE_LO && !trap_any
                            && !(best_prio > s_reg.prio)};
        end
        if (s_reg.state == CSE_ST_SAVEL) begin
            s_next.gmask = 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.state <= CSE_ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from state
    // vector index per trap
    assign mem_addr      = s_reg.addr;
    assign mem_we        = s_reg.we;
    assign mem_re        = s_reg.re;
    assign gpr_we        = s_reg.gwe;
    assign gpr_wmask     = s_reg.gmask;
    assign psw_out       = s_reg.program_status_word;
    assign pc_out        = s_reg.pc;
    assign previous_context_info_out      = s_reg.previous_context_info;
    assign entry_valid   = s_reg.ev;
    assign entry_is_trap = s_reg.etrap;
    assign entry_vector  = s_reg.evec;
    assign cur_prio      = s_reg.prio;
    assign done          = s_reg.done;
    always_comb begin
        for (int k = 0; k < 16; k++) begin
            mem_wdata[k] = s_reg.wbuf[k*32 +: 32];
        end
        for (int k = 0; k < 32; k++) begin
            gpr_wdata[k] = s_reg.gbuf[k*32 +: 32];
        end
    end
endmodule

`default_nettype wire

/* verif/cse_checker_assertions.sv */
/* checker: port relations of the context unit.
   assumes it is bound onto cse_context_unit with one clock. */
`timescale 1ns/1ns
`default_nettype none
module cse_checker import cse_pkg::*; #(
    parameter int PRIO_W = 8,
    parameter int TIN_W  = 8
) (
    input wire logic              clk,            // core clock
    input wire logic              rst_n,          // async reset
    input wire cse_op_e           op,             // pipeline request
    input wire cse_word_t         ret_pc,         // pc to save
    input wire cse_word_t         gpr_rdata [32], // register file
    input wire cse_word_t         psw_in,         // status word
    input wire cse_ptr_t          mem_addr,       // area word addr
    input wire logic              mem_we,         // burst write
    input wire logic              mem_re,         // burst read
    input wire cse_word_t         mem_wdata [16], // burst data
    input wire logic              gpr_we,         // reload strobe
    input wire logic [31:0]       gpr_wmask,      // regs reloaded
    input wire logic              done,           // op complete
    input wire logic              entry_valid,    // branch pulse
    input wire logic              entry_is_trap,  // trap vs irq
    input wire logic [TIN_W-1:0]  entry_vector,   // block index
    input wire logic [PRIO_W-1:0] cur_prio        // running prio
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    // zero pointer marks list end, so it is never written
    area_align_a: assert property (mem_we |-> mem_addr[3:0] == 4'h0 && mem_addr != 16'h0000)
        else $error("save area address misaligned or null");
    take_free_a: assert property (mem_we |-> $past(mem_re))
        else $error("burst write without free head read");
    // the write that frees an area on return comes with done itself
    save_done_a: assert property (mem_we && !done |=> done)
        else $error("done not one cycle after save");
    upper_fill_a: assert property (mem_we && !done && op != CSE_OP_SAVE_LO |->
        mem_wdata[1] == psw_in && mem_wdata[2] == gpr_rdata[26] && mem_wdata[8] == gpr_rdata[8])
        else $error("upper area contents wrong");
    lower_fill_a: assert property (mem_we && !done && op == CSE_OP_SAVE_LO |->
        mem_wdata[1] == ret_pc && mem_wdata[2] == gpr_rdata[18] && mem_wdata[8] == gpr_rdata[0])
        else $error("lower area contents wrong");
    // a trap entry writes only the id register besides whole reloads
    reload_mask_a: assert property (gpr_we |->
        gpr_wmask == 32'hfc00ff00 || gpr_wmask == 32'h00fc00ff
        || (entry_is_trap && gpr_wmask == 32'h00008000))
        else $error("reload mask not one whole context");
    reload_after_a: assert property (gpr_we && !entry_valid |-> done)
        else $error("register reload not together with done");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    irq_preempt_a: assert property (entry_valid && !entry_is_trap |->
        entry_vector > $past(cur_prio, 2))
        else $error("interrupt taken without higher priority");
endmodule
bind cse_context_unit cse_checker #(.PRIO_W(PRIO_W), .TIN_W(TIN_W)) u_chk (
    .clk(clk), .rst_n(rst_n), .op(op), .ret_pc(ret_pc), .gpr_rdata(gpr_rdata),
    .psw_in(psw_in), .mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re),
    .mem_wdata(mem_wdata), .gpr_we(gpr_we), .gpr_wmask(gpr_wmask),
    .done(done), .entry_valid(entry_valid), .entry_is_trap(entry_is_trap),
    .entry_vector(entry_vector), .cur_prio(cur_prio));
`default_nettype wire

/* verif/cse_save_mem.sv */
/* partner: on-chip save memory, sixteen areas of sixteen words.
   assumes pointers below 16 and same-cycle burst reads. */
`timescale 1ns/1ns
`default_nettype none
module cse_save_mem import cse_pkg::*; (
    input  wire logic      clk,            // core clock
    input  wire cse_ptr_t  mem_addr,       // area word address
    input  wire logic      mem_we,         // burst write
    input  wire logic      mem_re,         // burst read
    input  wire cse_word_t mem_wdata [16], // burst data in
    output cse_word_t      mem_rdata [16]  // burst data out
);
    cse_word_t area [16][16];
    logic      flip = 1'b0;
    always @(posedge clk) begin
        flip <= ~flip;
        if (mem_we)
            area[mem_addr[7:4]] <= mem_wdata;
    end
    // idle bus toggles so a stale value never looks valid
    always_comb begin
        for (int i = 0; i < 16; i++)
            mem_rdata[i] = mem_re ? area[mem_addr[7:4]][i] : {32{flip}};
    end
endmodule
`default_nettype wire

/* verif/context_switch_exception_entry_test.sv */
/* testbench: calls, returns, lower saves, interrupts and traps.
   assumes the save memory model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module context_switch_exception_entry_test;
    import cse_pkg::*;
    logic       clk = 0, rst_n = 0, free_load = 0;
    cse_op_e    op = CSE_OP_NONE;
    cse_word_t  ret_pc = '0, program_status_word = '0, psw_o, pc_o, previous_context_info_o;
    cse_word_t  mrd [16], mwd [16], gpr [32], gwd [32];
    cse_ptr_t   head = '0, maddr;
    logic [7:0] irq = '0, trq = '0, vec, prio_now, seen_vec, exp;
    logic [63:0] iprio = '0, tins = '0;
    logic       mwe, mre, gwe, ev, etrap, done;
    logic       seen_ev = 0, seen_trap = 0, seen_we = 0;
    logic [31:0] gmask, seen_mask;
    cse_word_t  seen_d8, seen_d0, seen_d15;
    int         mismatches = 0, checks_done = 0, lat;

    cse_context_unit dut (.clk(clk), .rst_n(rst_n), .op(op),
        .ret_pc(ret_pc), .free_head_in(head), .free_load(free_load),
        .irq_req(irq), .irq_prio(iprio), .trap_req(trq), .trap_tin(tins),
        .gpr_rdata(gpr), .psw_in(program_status_word), .mem_rdata(mrd), .mem_addr(maddr),
        .mem_we(mwe), .mem_re(mre), .mem_wdata(mwd), .gpr_we(gwe),
        .gpr_wmask(gmask), .gpr_wdata(gwd), .psw_out(psw_o), .pc_out(pc_o),
        .previous_context_info_out(previous_context_info_o), .entry_valid(ev), .entry_is_trap(etrap),
        .entry_vector(vec), .cur_prio(prio_now), .done(done));
    cse_save_mem ram (.clk(clk), .mem_addr(maddr), .mem_we(mwe),
        .mem_re(mre), .mem_wdata(mwd), .mem_rdata(mrd));

    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    // one-cycle pulses are caught here so no task can miss them
    always @(posedge clk) begin
        if (ev) begin
            seen_ev <= 1;
            seen_trap <= etrap;
            seen_vec <= vec;
        end
        if (mwe) seen_we <= 1;
        if (gwe) begin
            seen_mask <= gmask;
            seen_d8 <= gwd[8];
            seen_d0 <= gwd[0];
            seen_d15 <= gwd[15];
        end
    end
    task automatic chk(string what, logic [31:0] e, logic [31:0] got);
        checks_done++;
        if (e !== got) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // requests are dropped just after done so none is taken twice
    task automatic wait_done();
        lat = 0;
        do begin
            @(posedge clk);
            #1 lat++;
        end while (done !== 1'b1 && lat < 30);
        if (done !== 1'b1) begin
            mismatches++;
            $display("BAD done expected 1 seen %b", done);
            test_done();
        end
        #1 op = CSE_OP_NONE;
        trq = '0;
    endtask
    task automatic go(cse_op_e o);
        @(posedge clk);
        #2 op = o;
        {seen_ev, seen_we} = '0;
        wait_done();
    endtask
    // areas 1..3 chained, zero ends the list
    task automatic refill();
        for (int k = 1; k < 4; k++) ram.area[k][0] = (k == 3) ? 0 : k + 1;
        @(posedge clk);
        #2 free_load = 1;
        head = 16'h0001;
        @(posedge clk);
        #2 free_load = 0;
    endtask
    function automatic logic [7:0] min_tin(logic [7:0] rq, logic [63:0] t);
        logic [7:0] m = 8'hff;
        for (int i = 0; i < 8; i++)
            if (rq[i] && t[i*8+:8] < m) m = t[i*8+:8];
        return m;
    endfunction

    initial begin
        void'($urandom(32'h447b));
        for (int i = 0; i < 32; i++) gpr[i] = $urandom;
        program_status_word = $urandom;
        ret_pc = $urandom;
        repeat (12) @(posedge clk);
        #2 rst_n = 1;
        refill();
        go(CSE_OP_CALL);
        chk("save latency", 3, lat - 1);
        chk("saved psw", program_status_word, ram.area[1][1]);
        chk("saved A11", gpr[27], ram.area[1][3]);
        chk("saved D9", gpr[9], ram.area[1][9]);
        chk("chain link", 1, previous_context_info_o);
        go(CSE_OP_RET);
        chk("load latency", 2, lat - 1);
        chk("chain end", 0, previous_context_info_o);
        repeat (2) @(posedge clk);
        chk("upper mask", 32'hfc00ff00, seen_mask);
        chk("reloaded D8", gpr[8], seen_d8);
        chk("restored psw", program_status_word, psw_o);
        refill();
        go(CSE_OP_SAVE_LO);
        chk("saved pc", ret_pc, ram.area[1][1]);
        chk("saved D0", gpr[0], ram.area[1][8]);
        go(CSE_OP_RESTORE_LO);
        repeat (2) @(posedge clk);
        chk("lower mask", 32'h00fc00ff, seen_mask);
        chk("reloaded D0", gpr[0], seen_d0);
        chk("restored pc", ret_pc, pc_o);
        refill();
        iprio = 64'h0007_0005_0005_0000;
        seen_ev = 0;
        irq = 8'h04;
        wait_done();
        chk("irq vector", 5, 32'(seen_vec));
        chk("irq prio", 5, 32'(prio_now));
        seen_ev = 0;
        irq = 8'h14;
        repeat (10) @(posedge clk);
        chk("equal prio entry", 0, 32'(seen_ev));
        #2 irq = 8'h54;
        wait_done();
        chk("nested vector", 7, 32'(seen_vec));
        irq = '0;
        go(CSE_OP_RET);
        chk("prio after return", 0, 32'(prio_now));
        // two areas are left on the list, the third call finds it empty
        go(CSE_OP_CALL);
        go(CSE_OP_CALL);
        go(CSE_OP_CALL);
        chk("empty trap", 1, 32'(seen_trap));
        chk("empty trap id", 32'h04, 32'(seen_vec));
        chk("empty write", 0, 32'(seen_we));
        for (int i = 0; i < 8; i++) begin
            refill();
            for (int j = 0; j < 8; j++) tins[j*8+:8] = $urandom_range(1, 254);
            seen_ev = 0;
            trq = 8'(1 << i) | 8'($urandom);
            exp = min_tin(trq, tins);
            wait_done();
            chk("trap taken", 1, 32'({seen_ev, seen_trap} == 2'b11));
            chk("trap vector", 32'(exp), 32'(seen_vec));
            chk("trap id mask", 32'h0000_8000, seen_mask);
            chk("trap id in D15", 32'(exp), seen_d15);
        end
        test_done();
    end
endmodule
`default_nettype wire
